// File: design/pse_consts.svh
`ifndef PSE_CONSTS_SVH
`define PSE_CONSTS_SVH

// Register command codes
`define PSE_REG_GEN_MASK     8'h17
`define PSE_REG_RESTART      8'h18
`define PSE_REG_POWER        8'h19
`define PSE_REG_RESET        8'h1a

// General configuration mask fields and reset value
`define PSE_GM_IRQ_GATE      7
`define PSE_GM_ACCESS_WIDTH  5
`define PSE_GM_PRIO_WIDTH    4
`define PSE_GM_CLASS_CHG     3
`define PSE_GM_DETECT_CHG    2
`define PSE_GM_RESET_VAL     8'h80

// Reset command fields
`define PSE_RC_CLEAR_ALL     7
`define PSE_RC_RELEASE_IRQ   6

// Serial bus slave address of the first four-port half (arbitrary value)
`define PSE_SLAVE_ADDR       7'h20

`endif

// File: design/pse_pkg.sv
package pse_pkg;

   // One register byte written by the host
   typedef struct packed {
      logic       valid;
      logic       half;
      logic [7:0] addr;
      logic [7:0] data;
   } pse_wr_t;

   typedef enum logic [3:0] {
      PSE_IDLE    = 4'b0000,
      PSE_ADDR    = 4'b0001,
      PSE_ACK_ADR = 4'b0010,
      PSE_PTR     = 4'b0011,
      PSE_ACK_PTR = 4'b0100,
      PSE_WDATA   = 4'b0101,
      PSE_ACK_WR  = 4'b0110,
      PSE_RDATA   = 4'b0111,
      PSE_RACK    = 4'b1000
   } pse_bus_state_t;

endpackage

// File: design/pse_serial_slave.sv
`timescale 1ns/1ps
`include "pse_consts.svh"

module pse_serial_slave (
   input  wire logic           sys_clk,
   input  wire logic           rst_b,
   input  wire logic           scl_in,
   input  wire logic           sda_in,
   output logic                sda_oe_b,
   input  wire logic           access_wide,
   input  wire logic [7:0]     rd_data,
   output logic [7:0]          rd_addr,
   output logic                rd_half,
   output pse_pkg::pse_wr_t    wr
);
   import pse_pkg::*;

   logic [2:0]     scl_s_q;
   logic [2:0]     sda_s_q;
   pse_bus_state_t st_q;
   logic [7:0]     sh_q;
   logic [3:0]     cnt_q;
   logic [7:0]     ptr_q;
   logic           half_q;
   logic [7:0]     out_q;
   logic           rw_q;

   // Two-flop synchronisers, third stage for edge finding
   always_ff @(posedge sys_clk) begin
      scl_s_q <= {scl_s_q[1:0], scl_in};
      sda_s_q <= {sda_s_q[1:0], sda_in};
   end

   wire scl_rise = scl_s_q[1] & ~scl_s_q[2];
   wire scl_fall = ~scl_s_q[1] & scl_s_q[2];
   wire start_c  = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
   wire stop_c   = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];
   wire [6:0] dev_addr = sh_q[7:1];
   wire hit_lo   = dev_addr == `PSE_SLAVE_ADDR;
   wire hit_hi   = ~access_wide & (dev_addr == 7'(`PSE_SLAVE_ADDR + 7'h01));
   wire bit_out  = out_q[3'(4'h7 - cnt_q)];

   assign rd_addr = ptr_q;
   assign rd_half = half_q;

   // Byte engine: shift on rising clock, drive on falling clock
   always_ff @(posedge sys_clk) begin
      wr.valid <= 1'b0;
      if (!rst_b) begin
         st_q     <= PSE_IDLE;
         sh_q     <= 8'h00;
         cnt_q    <= 4'h0;
         ptr_q    <= 8'h00;
         half_q   <= 1'b0;
         out_q    <= 8'h00;
         rw_q     <= 1'b0;
         sda_oe_b <= 1'b1;
         wr       <= '0;
      end else if (start_c) begin
         st_q     <= PSE_ADDR;
         cnt_q    <= 4'h0;
         sda_oe_b <= 1'b1;
      end else if (stop_c) begin
         st_q     <= PSE_IDLE;
         sda_oe_b <= 1'b1;
      end else if (scl_rise) begin
         if (st_q == PSE_RACK) begin
            if (sda_s_q[1]) st_q <= PSE_IDLE;   // Master ended the read
         end else begin
            sh_q  <= {sh_q[6:0], sda_s_q[1]};
            cnt_q <= cnt_q + 4'h1;
         end
      end else if (scl_fall) begin
         case (st_q)
            PSE_ADDR: if (cnt_q == 4'h8) begin
               if (hit_lo | hit_hi) begin
                  half_q   <= hit_hi;
                  rw_q     <= sh_q[0];             // Direction bit, lost once ACK shifts in
                  sda_oe_b <= 1'b0;
                  st_q     <= PSE_ACK_ADR;
               end else begin
                  st_q <= PSE_IDLE;
               end
            end
            PSE_ACK_ADR: begin
               cnt_q <= 4'h0;
               if (rw_q) begin
                  out_q    <= rd_data;
                  sda_oe_b <= rd_data[7];
                  st_q     <= PSE_RDATA;
               end else begin
                  sda_oe_b <= 1'b1;
                  st_q     <= PSE_PTR;
               end
            end
            PSE_PTR: if (cnt_q == 4'h8) begin
               ptr_q    <= sh_q;
               if (access_wide) half_q <= 1'b0;
               sda_oe_b <= 1'b0;
               st_q     <= PSE_ACK_PTR;
            end
            PSE_ACK_PTR, PSE_ACK_WR: begin
               sda_oe_b <= 1'b1;
               cnt_q    <= 4'h0;
               st_q     <= PSE_WDATA;
            end
            PSE_WDATA: if (cnt_q == 4'h8) begin
               wr       <= '{valid: 1'b1, half: half_q, addr: ptr_q, data: sh_q};
               sda_oe_b <= 1'b0;
               st_q     <= PSE_ACK_WR;
               if (access_wide) half_q <= ~half_q;
               if (!access_wide || half_q) ptr_q <= ptr_q + 8'h01;
            end
            PSE_RDATA: begin
               if (cnt_q == 4'h8) begin
                  sda_oe_b <= 1'b1;
                  st_q     <= PSE_RACK;
               end else begin
                  sda_oe_b <= bit_out;
               end
            end
            PSE_RACK: begin
               if (access_wide) half_q <= ~half_q;
               if (!access_wide || half_q) ptr_q <= ptr_q + 8'h01;
               cnt_q <= 4'h0;
               st_q  <= PSE_ACK_ADR;                // Reload next byte on next fall
               sda_oe_b <= 1'b1;
            end
            default: st_q <= st_q;
         endcase
      end
   end

endmodule

// File: design/pse_port_command_registers.sv
`timescale 1ns/1ps
`include "pse_consts.svh"

module pse_port_command_registers (
   input  wire logic           sys_clk,
   input  wire logic           rst_b,
   input  wire logic           scl_in,
   input  wire logic           sda_in,
   output logic                sda_oe_b,
   input  wire logic           turn_on_timing_check,
   input  wire logic [7:0]     port_manual,
   input  wire logic [7:0]     cool_down,
   input  wire logic [7:0]     fault_hold,
   input  wire logic [7:0]     det_done,
   input  wire logic [7:0]     det_valid,
   input  wire logic [7:0]     det_changed,
   input  wire logic [7:0]     cls_done,
   input  wire logic [7:0]     cls_valid,
   input  wire logic [7:0]     cls_changed,
   input  wire logic [7:0]     timing_met,
   input  wire logic           irq_pending,
   input  wire logic           irq_new_event,
   output logic                irq_out_b,
   output logic                access_width_select,
   output logic                priority_width_select,
   output logic                clear_all_interrupts,
   output logic [7:0]          power_enable_status,
   output logic [7:0]          detect_enable_field,
   output logic [7:0]          class_enable_bit,
   output logic [7:0]          det_run,
   output logic [7:0]          cls_run,
   output logic [7:0]          detect_event_flag,
   output logic [7:0]          class_event_flag,
   output logic [7:0]          port_clear,
   output logic [7:0]          power_change_flag,
   output logic [7:0]          cooldown_abort
);
   import pse_pkg::*;

   pse_wr_t    wr;
   logic [7:0] rd_addr;
   logic       rd_half;
   logic [7:0] gen_mask_q;
   logic       released_q;
   logic [7:0] pwr_q;
   logic [7:0] pend_q;
   logic [7:0] det_req_q;
   logic [7:0] cls_req_q;
   logic [7:0] det_en_q;
   logic [7:0] cls_en_q;

   // Read decode: only the mask holds state, command bytes read as zero
   wire        rd_mask = rd_addr == `PSE_REG_GEN_MASK;
   wire [7:0]  rd_data = (rd_mask && !rd_half) ? gen_mask_q : 8'h00;

   // Register byte transport from the serial management bus
   pse_serial_slave u_slave (
      .sys_clk     (sys_clk),
      .rst_b       (rst_b),
      .scl_in      (scl_in),
      .sda_in      (sda_in),
      .sda_oe_b    (sda_oe_b),
      .access_wide (gen_mask_q[`PSE_GM_ACCESS_WIDTH]),
      .rd_data     (rd_data),
      .rd_addr     (rd_addr),
      .rd_half     (rd_half),
      .wr          (wr)
   );

   // Write decode
   wire        wr_mask    = wr.valid & (wr.addr == `PSE_REG_GEN_MASK) & ~wr.half;
   wire        wr_restart = wr.valid & (wr.addr == `PSE_REG_RESTART);
   wire        wr_power   = wr.valid & (wr.addr == `PSE_REG_POWER);
   wire        wr_reset   = wr.valid & (wr.addr == `PSE_REG_RESET);
   wire        clr_all    = wr_reset & wr.data[`PSE_RC_CLEAR_ALL];
   wire        rel_irq    = clr_all | (wr_reset & wr.data[`PSE_RC_RELEASE_IRQ]);
   wire        irq_gate   = gen_mask_q[`PSE_GM_IRQ_GATE];
   wire        det_chg_only = gen_mask_q[`PSE_GM_DETECT_CHG];
   wire        cls_chg_only = gen_mask_q[`PSE_GM_CLASS_CHG];

   // General configuration mask, all bits read/write
   always_ff @(posedge sys_clk) begin
      if (!rst_b) gen_mask_q <= `PSE_GM_RESET_VAL;
      else if (wr_mask) gen_mask_q <= wr.data;
   end

   // Configuration outputs for the shutdown and access logic
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         access_width_select   <= 1'b0;
         priority_width_select <= 1'b0;
      end else begin
         access_width_select   <= gen_mask_q[`PSE_GM_ACCESS_WIDTH];
         priority_width_select <= gen_mask_q[`PSE_GM_PRIO_WIDTH];
      end
   end

   // Pin release: a new event re-arms the pin and wins over a release
   always_ff @(posedge sys_clk) begin
      if (!rst_b) released_q <= 1'b0;
      else if (irq_new_event) released_q <= 1'b0;
      else if (rel_irq) released_q <= 1'b1;
   end

   // Interrupt pin and clear-all pulse; gate touches only the pin
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         irq_out_b            <= 1'b1;
         clear_all_interrupts <= 1'b0;
      end else begin
         irq_out_b            <= ~(irq_gate & irq_pending & ~released_q);
         clear_all_interrupts <= clr_all;
      end
   end

   // Per-port command handling
   genvar p;
   generate
      for (p = 0; p < 8; p++) begin : g_port
         localparam logic H = 1'(p / 4);
         localparam int   N = p % 4;

         wire hit      = wr.half == H;
         wire on_req   = wr_power & hit & wr.data[N];
         wire off_req  = wr_power & hit & wr.data[N + 4];
         wire force_rq = wr_reset & hit & wr.data[N];
         wire rs_det   = wr_restart & hit & wr.data[N];
         wire rs_cls   = wr_restart & hit & wr.data[N + 4];
         wire manual   = port_manual[p];
         wire turn_off = off_req | force_rq;
         wire hold     = cool_down[p] | fault_hold[p];
         wire act_det  = (det_req_q[p] | rs_det) & ~cool_down[p];
         wire act_cls  = (cls_req_q[p] | rs_cls) & ~cool_down[p];
         wire direct   = ~turn_on_timing_check | manual | ~det_en_q[p];
         wire ok_now   = det_valid[p] & (cls_valid[p] | ~cls_en_q[p]) & timing_met[p];
         wire on_now   = on_req & ~hold & (direct | ok_now);
         wire retry    = on_req & ~hold & ~direct & ~ok_now;
         wire retry_ok = pend_q[p] & det_done[p] & ok_now & ~hold;
         wire cycling  = ~manual & ~pwr_q[p] & ~hold & det_done[p];

         // Port power state; turn-off wins over every turn-on source
         always_ff @(posedge sys_clk) begin
            if (!rst_b) pwr_q[p] <= 1'b0;
            else if (turn_off || fault_hold[p]) pwr_q[p] <= 1'b0;
            else if (on_now || retry_ok) pwr_q[p] <= 1'b1;
         end

         // Single retry after a missed turn-on timing window
         always_ff @(posedge sys_clk) begin
            if (!rst_b) pend_q[p] <= 1'b0;
            else if (turn_off || (pend_q[p] && det_done[p])) pend_q[p] <= 1'b0;
            else if (retry) pend_q[p] <= 1'b1;
         end

         // Restart requests parked through cool-down
         always_ff @(posedge sys_clk) begin
            if (!rst_b || turn_off) begin
               det_req_q[p] <= 1'b0;
               cls_req_q[p] <= 1'b0;
            end else begin
               det_req_q[p] <= (det_req_q[p] | rs_det) & cool_down[p];
               cls_req_q[p] <= (cls_req_q[p] | rs_cls) & cool_down[p];
            end
         end

         // Detect and class enable bits: set by semiauto restart, cleared on turn-off
         always_ff @(posedge sys_clk) begin
            if (!rst_b || turn_off) begin
               det_en_q[p] <= 1'b0;
               cls_en_q[p] <= 1'b0;
            end else begin
               if (act_det && !manual) det_en_q[p] <= 1'b1;
               if (act_cls && !manual) cls_en_q[p] <= 1'b1;
            end
         end

         // Cycle launch pulses toward the detection and class engines
         always_ff @(posedge sys_clk) begin
            if (!rst_b) begin
               det_run[p] <= 1'b0;
               cls_run[p] <= 1'b0;
            end else begin
               det_run[p] <= (act_det & (manual | ~pwr_q[p])) | retry
                           | (cycling & det_en_q[p]);
               cls_run[p] <= (act_cls & (manual | ~pwr_q[p]))
                           | (cls_en_q[p] & det_valid[p] & (cycling | pend_q[p] & det_done[p]));
            end
         end

         // Event flag set pulses, optionally only on a changed result
         always_ff @(posedge sys_clk) begin
            if (!rst_b) begin
               detect_event_flag[p] <= 1'b0;
               class_event_flag[p]  <= 1'b0;
            end else begin
               detect_event_flag[p] <= det_done[p] & (~det_chg_only | det_changed[p]);
               class_event_flag[p]  <= cls_done[p] & (~cls_chg_only | cls_changed[p]);
            end
         end

         // Turn-off side effects: clear pulse, change flags, cool-down abort
         always_ff @(posedge sys_clk) begin
            if (!rst_b) begin
               port_clear[p]        <= 1'b0;
               power_change_flag[p] <= 1'b0;
               cooldown_abort[p]    <= 1'b0;
            end else begin
               port_clear[p]        <= turn_off;
               power_change_flag[p] <= turn_off & pwr_q[p];
               cooldown_abort[p]    <= force_rq;
            end
         end
      end
   endgenerate

   // Status mirrors of held state
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         power_enable_status <= 8'h00;
         detect_enable_field <= 8'h00;
         class_enable_bit    <= 8'h00;
      end else begin
         power_enable_status <= pwr_q;
         detect_enable_field <= det_en_q;
         class_enable_bit    <= cls_en_q;
      end
   end

endmodule

// File: test/pse_pcr_asserts.sv
`timescale 1ns/1ps

module pse_pcr_asserts (
   input wire logic       sys_clk,
   input wire logic       rst_b,
   input wire logic       irq_pending,
   input wire logic       irq_out_b,
   input wire logic [7:0] cool_down,
   input wire logic [7:0] fault_hold,
   input wire logic [7:0] det_done,
   input wire logic [7:0] cls_done,
   input wire logic [7:0] det_run,
   input wire logic [7:0] detect_event_flag,
   input wire logic [7:0] class_event_flag,
   input wire logic [7:0] port_clear,
   input wire logic [7:0] power_change_flag,
   input wire logic [7:0] power_enable_status,
   input wire logic [7:0] cooldown_abort
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   // Status of the ports named by a clear pulse reads off one cycle later
   sequence s_cmd_off;
      ##1 ((power_enable_status & $past(port_clear)) == 8'h00);
   endsequence
   // Status of faulted ports reads off two cycles later
   sequence s_fault_off;
      ##2 ((power_enable_status & $past(fault_hold, 2)) == 8'h00);
   endsequence

   // Port power, clearing, detection start, event flag and interrupt pin relations
   a_irq_cause: assert property ($fell(irq_out_b) |-> $past(irq_pending) || $past(irq_pending, 2))
      else $error("interrupt pin asserted with nothing pending");
   a_run_once: assert property ((det_run != 8'h00) |=> (det_run & $past(det_run)) == 8'h00)
      else $error("detection start held longer than one cycle");
   a_off_clears: assert property ((port_clear != 8'h00) |-> s_cmd_off)
      else $error("cleared port still powered");
   a_off_change: assert property (((port_clear & power_enable_status) != 8'h00) |->
      ((port_clear & power_enable_status & ~power_change_flag) == 8'h00))
      else $error("turn-off of a powered port without change flag");
   a_abort_clear: assert property ((cooldown_abort != 8'h00) |->
      ((cooldown_abort & ~port_clear) == 8'h00))
      else $error("cool-down ended without port clearing");
   a_fault_off: assert property ((fault_hold != 8'h00) |-> s_fault_off)
      else $error("faulted port still powered");
   a_cool_no_on: assert property (((power_enable_status & ~$past(power_enable_status)) != 8'h00)
      |-> ((power_enable_status & ~$past(power_enable_status) & $past(cool_down, 2)) == 8'h00))
      else $error("port powered during cool-down");
   a_flag_cause: assert property ((detect_event_flag | class_event_flag) != 8'h00 |->
      ((detect_event_flag & ~$past(det_done)) | (class_event_flag & ~$past(cls_done))) == 8'h00)
      else $error("event flag without a finished cycle");
endmodule

bind pse_port_command_registers pse_pcr_asserts chk_u (
   .sys_clk, .rst_b, .irq_pending, .irq_out_b, .cool_down, .fault_hold, .det_done, .cls_done,
   .det_run, .detect_event_flag, .class_event_flag, .port_clear, .power_change_flag,
   .power_enable_status, .cooldown_abort
);

// File: test/pse_host_model.sv
`timescale 1ns/1ps

module pse_host_model (
   output logic     scl_in,
   output logic     sda_in,
   input wire logic sda_oe_b
);
   logic drv = 1'b1;
   logic x;

   // Open-drain data line with pull-up; clock idles high between frames
   assign sda_in = drv & sda_oe_b;
   initial scl_in = 1'b1;

   // One 80 ns bit slot: data changes while clock is low, sampled while high
   task automatic bit_io(input logic b, output logic s);
      #20 drv = b;
      #20 scl_in = 1'b1;
      #20 s = sda_in;
      #20 scl_in = 1'b0;
   endtask
   task automatic byte_io(input logic [7:0] b, output logic [7:0] r, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], r[i]);
      end
      bit_io(1'b1, s);
      ack = !s;
   endtask
   task automatic start_c();
      #20 drv = 1'b1;
      #20 scl_in = 1'b1;
      #20 drv = 1'b0;
      #20 scl_in = 1'b0;
   endtask
   task automatic stop_c();
      #20 drv = 1'b0;
      #20 scl_in = 1'b1;
      #20 drv = 1'b1;
   endtask
   // Address, pointer, then one data byte written or read; ok when all ACKs seen
   task automatic xfer(input logic [6:0] dev, input logic [7:0] ptr, input logic rd,
                       input logic [7:0] d, output logic [7:0] q, output logic ok);
      logic [7:0] r;
      logic       a1, a2, a3;
      start_c();
      byte_io({dev, 1'b0}, r, a1);
      byte_io(ptr, r, a2);
      if (rd) begin
         start_c();
         byte_io({dev, 1'b1}, r, a3);
         byte_io(8'hff, q, x);
      end else begin
         byte_io(d, r, a3);
      end
      stop_c();
      ok = a1 & a2 & a3;
   endtask
endmodule

// File: test/tb_pse_port_command_registers.sv
`timescale 1ns/1ps
`include "pse_consts.svh"

module tb_pse_port_command_registers;
   localparam logic [6:0] A0 = `PSE_SLAVE_ADDR;
   localparam logic [6:0] A1 = A0 + 7'h01;
   logic       sys_clk, rst_b, scl_in, sda_in, sda_oe_b, turn_on_timing_check, acc_clr, ok;
   logic       irq_pending, irq_new_event, irq_out_b, access_width_select;
   logic       priority_width_select, clear_all_interrupts;
   logic [7:0] port_manual, cool_down, fault_hold, det_done, det_valid, det_changed, rd;
   logic [7:0] cls_done, cls_valid, cls_changed, timing_met, power_enable_status;
   logic [7:0] detect_enable_field, class_enable_bit, det_run, cls_run, cooldown_abort;
   logic [7:0] detect_event_flag, class_event_flag, port_clear, power_change_flag;
   logic [7:0][7:0] acc;
   int         n_errors = 0;
   int         checked = 0;

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   pse_port_command_registers dut_u (
      .sys_clk, .rst_b, .scl_in, .sda_in, .sda_oe_b, .turn_on_timing_check, .port_manual,
      .cool_down, .fault_hold, .det_done, .det_valid, .det_changed, .cls_done, .cls_valid,
      .cls_changed, .timing_met, .irq_pending, .irq_new_event, .irq_out_b,
      .access_width_select, .priority_width_select, .clear_all_interrupts,
      .power_enable_status, .detect_enable_field, .class_enable_bit, .det_run, .cls_run,
      .detect_event_flag, .class_event_flag, .port_clear, .power_change_flag, .cooldown_abort
   );
   pse_host_model host_u (.scl_in, .sda_in, .sda_oe_b);

   // Collect one-cycle pulses: 0 clear-all, 1 det run, 2 cls run, 3-4 flags, 5-7 port
   always @(posedge sys_clk) begin
      if (acc_clr) begin
         acc <= '0;
      end else begin
         acc <= acc | {cooldown_abort, power_change_flag, port_clear, class_event_flag,
                       detect_event_flag, cls_run, det_run, {7'h00, clear_all_interrupts}};
      end
   end

   task automatic ck(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic clr_acc();
      @(posedge sys_clk);
      acc_clr <= 1'b1;
      @(posedge sys_clk);
      acc_clr <= 1'b0;
   endtask
   task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d);
      clr_acc();
      #1 host_u.xfer(dev, ptr, 1'b0, d, rd, ok);
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic rck(input string n, input logic [7:0] ptr, input logic [7:0] e);
      @(posedge sys_clk);
      #1 host_u.xfer(A0, ptr, 1'b1, 8'h00, rd, ok);
      ck(n, e, rd);
   endtask
   task automatic irq_event();
      @(posedge sys_clk);
      irq_new_event <= 1'b1;
      @(posedge sys_clk);
      irq_new_event <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask
   // Finished detection and class on port 0 with a given change indication
   task automatic engine(input logic [7:0] chg);
      clr_acc();
      {det_done, cls_done, det_changed, cls_changed} <= {8'h01, 8'h01, chg, chg};
      @(posedge sys_clk);
      {det_done, cls_done} <= 16'h0000;
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic print_verdict();
      if (n_errors == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Some 30 bus frames of about 2.5 us each; the limit leaves a wide margin
   initial begin
      #400000;
      n_errors++;
      print_verdict();
   end

   initial begin
      {port_manual, cool_down, fault_hold, det_done, det_valid, det_changed} = '0;
      {cls_done, cls_valid, cls_changed, timing_met} = '0;
      {turn_on_timing_check, irq_pending, irq_new_event, rst_b, acc_clr} = 5'h01;
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge sys_clk);
      ck("irq_out_b", 8'h01, {7'h00, irq_out_b});
      rck("mask", `PSE_REG_GEN_MASK, 8'h80);
      irq_pending <= 1'b1;
      irq_event();
      ck("irq_out_b", 8'h00, {7'h00, irq_out_b});
      wr(A0, `PSE_REG_RESET, 8'h40);
      ck("irq_out_b", 8'h01, {7'h00, irq_out_b});
      ck("clear_all", 8'h00, acc[0]);
      wr(A0, `PSE_REG_GEN_MASK, 8'h00);
      ck("clear_all", 8'h00, acc[0]);
      irq_event();
      ck("irq_out_b", 8'h01, {7'h00, irq_out_b});
      wr(A0, `PSE_REG_GEN_MASK, 8'h80);
      irq_event();
      ck("irq_out_b", 8'h00, {7'h00, irq_out_b});
      wr(A0, `PSE_REG_RESET, 8'h80);
      ck("clear_all", 8'h01, acc[0]);
      ck("irq_out_b", 8'h01, {7'h00, irq_out_b});
      irq_pending <= 1'b0;
      // Access and priority width selects; no shutdown stream runs here, it idles low
      wr(A0, `PSE_REG_GEN_MASK, 8'h30);
      ck("widths", 8'h03, {6'h00, access_width_select, priority_width_select});
      rck("mask", `PSE_REG_GEN_MASK, 8'h30);
      wr(A1, `PSE_REG_POWER, 8'h01);
      ck("ack_wide", 8'h00, {7'h00, ok});
      wr(A0, `PSE_REG_GEN_MASK, 8'h80);
      ck("widths", 8'h00, {6'h00, access_width_select, priority_width_select});
      // Manual power on and off, both halves
      port_manual <= 8'hff;
      wr(A1, `PSE_REG_POWER, 8'h01);
      ck("ack_half", 8'h01, {7'h00, ok});
      ck("pes", 8'h10, power_enable_status);
      wr(A1, `PSE_REG_POWER, 8'h11);
      ck("pes", 8'h00, power_enable_status);
      ck("port_clear", 8'h10, acc[5]);
      ck("pwr_change", 8'h10, acc[6]);
      wr(A0, `PSE_REG_POWER, 8'h22);
      ck("port_clear", 8'h02, acc[5]);
      ck("pwr_change", 8'h00, acc[6]);
      cool_down <= 8'h04;
      wr(A0, `PSE_REG_POWER, 8'h04);
      ck("pes", 8'h00, power_enable_status);
      wr(A0, `PSE_REG_RESET, 8'h04);
      ck("cool_abort", 8'h04, acc[7]);
      cool_down <= 8'h00;
      wr(A0, `PSE_REG_POWER, 8'h08);
      ck("pes", 8'h08, power_enable_status);
      wr(A0, `PSE_REG_RESET, 8'h08);
      ck("pes", 8'h00, power_enable_status);
      ck("pwr_change", 8'h08, acc[6]);
      wr(A0, `PSE_REG_POWER, 8'h08);
      fault_hold <= 8'h08;
      repeat (4) @(posedge sys_clk);
      ck("pes", 8'h00, power_enable_status);
      fault_hold <= 8'h00;
      // Restarts and push-button reads
      wr(A0, `PSE_REG_RESTART, 8'h5a);
      ck("det_run", 8'h0a, acc[1]);
      ck("cls_run", 8'h05, acc[2]);
      rck("restart", `PSE_REG_RESTART, 8'h00);
      rck("power", `PSE_REG_POWER, 8'h00);
      rck("reset", `PSE_REG_RESET, 8'h00);
      rck("unmapped", 8'h30, 8'h00);
      wr(A0 + 7'h02, `PSE_REG_POWER, 8'h01);
      ck("ack_other", 8'h00, {7'h00, ok});
      cool_down <= 8'h01;
      wr(A0, `PSE_REG_RESTART, 8'h01);
      ck("det_run", 8'h00, acc[1]);
      clr_acc();
      cool_down <= 8'h00;
      repeat (6) @(posedge sys_clk);
      ck("det_run", 8'h01, acc[1]);
      // Semiautomatic power-on gating
      port_manual <= 8'h00;
      turn_on_timing_check <= 1'b1;
      wr(A0, `PSE_REG_POWER, 8'h01);
      ck("pes", 8'h01, power_enable_status);
      wr(A0, `PSE_REG_POWER, 8'h10);
      wr(A0, `PSE_REG_RESTART, 8'h01);
      ck("det_enable", 8'h01, detect_enable_field);
      wr(A0, `PSE_REG_POWER, 8'h01);
      ck("pes", 8'h00, power_enable_status);
      ck("det_run", 8'h01, acc[1]);
      {det_valid, timing_met} <= 16'h0101;
      wr(A0, `PSE_REG_POWER, 8'h01);
      ck("pes", 8'h01, power_enable_status);
      wr(A0, `PSE_REG_POWER, 8'h10);
      ck("det_enable", 8'h00, detect_enable_field);
      // Unpowered semiauto port keeps cycling while both enables stand
      wr(A0, `PSE_REG_RESTART, 8'h11);
      ck("cls_enable", 8'h01, class_enable_bit);
      engine(8'h00);
      ck("det_run", 8'h01, acc[1]);
      ck("cls_run", 8'h01, acc[2]);
      // Event flags, every cycle and change-only
      engine(8'h00);
      ck("flags", 8'h11, {acc[4][3:0], acc[3][3:0]});
      wr(A0, `PSE_REG_GEN_MASK, 8'h8c);
      engine(8'h00);
      ck("flags", 8'h00, {acc[4][3:0], acc[3][3:0]});
      engine(8'h01);
      ck("flags", 8'h11, {acc[4][3:0], acc[3][3:0]});
      print_verdict();
   end
endmodule
